// File: hdl/cta_pkg.sv
package cta_pkg;
  // ***************************************************
  // Register word indices (byte address = 4 * index)
  // ***************************************************
  localparam logic [3:0] IDX_COUNT_A = 4'h0;
  localparam logic [3:0] IDX_PERIOD_A = 4'h1;
  localparam logic [3:0] IDX_CTRL_A = 4'h2;
  localparam logic [3:0] IDX_LOWER_COUNT = 4'h3;
  localparam logic [3:0] IDX_LOWER_PERIOD = 4'h4;
  localparam logic [3:0] IDX_LOWER_CTRL = 4'h5;
  localparam logic [3:0] IDX_UPPER_COUNT = 4'h6;
  localparam logic [3:0] IDX_UPPER_PERIOD = 4'h7;
  localparam logic [3:0] IDX_UPPER_CTRL = 4'h8;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'h9;
  localparam logic [3:0] IDX_IRQ_FLAG = 4'hA;
  localparam logic [3:0] IDX_IRQ_PRIORITY = 4'hB;
  localparam logic [3:0] IDX_OSC_CTRL = 4'hC;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int RUN_BIT = 15;
  localparam int PRESCALE_LSB = 4;
  localparam int WIDE_MODE_BIT = 3;
  localparam int CLOCK_SOURCE_BIT = 1;
  localparam int LP_CRYSTAL_EN_BIT = 1;
  localparam int IRQ_BIT_A = 3;
  localparam int IRQ_BIT_LOWER = 6;
  localparam int IRQ_BIT_UPPER = 7;
  localparam int PRIO_LSB_A = 0;
  localparam int PRIO_LSB_LOWER = 8;
  localparam int PRIO_LSB_UPPER = 12;

  // ***************************************************
  // Reset values and prescaler terminal counts
  // ***************************************************
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [7:0] PS_LAST_1 = 8'h00;
  localparam logic [7:0] PS_LAST_8 = 8'h07;
  localparam logic [7:0] PS_LAST_64 = 8'h3F;
  localparam logic [7:0] PS_LAST_256 = 8'hFF;

  typedef enum logic [1:0]
  {
    PS_DIV1 = 2'b00,
    PS_DIV8 = 2'b01,
    PS_DIV64 = 2'b10,
    PS_DIV256 = 2'b11
  } cta_prescale_t;
endpackage

// File: hdl/cta_timer.sv
// Decided for this implementation: the Avalon-MM register port and the address map.
module cta_timer
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  input wire logic external_count_pin_a_in,
  input wire logic external_count_pin_lower_in,
  input wire logic external_count_pin_upper_in,
  input wire logic lowpower_osc_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  output logic irq_a_out,
  output logic irq_lower_out,
  output logic wide_irq_out
);
  // ***************************************************
  // State
  // ***************************************************
  logic [15:0] count_register [3];
  logic [15:0] period_register [3];
  logic [15:0] timer_control_register [3];
  logic [7:0] presc [3];
  logic [2:0] src_prev;
  logic [15:0] irq_enable_reg_zero;
  logic [15:0] irq_flag_reg_zero;
  logic [15:0] irq_priority_reg_one;
  logic [15:0] oscillator_control_register;
  logic [15:0] next_count [3];
  logic [7:0] next_presc [3];
  logic [2:0] src_lvl;
  logic [2:0] wr_cnt;
  logic [2:0] inc;
  logic [2:0] set_flag;

  function automatic logic [7:0] ps_last(input logic [1:0] sel);
    case (cta_pkg::cta_prescale_t'(sel))
      cta_pkg::PS_DIV1: ps_last = cta_pkg::PS_LAST_1;
      cta_pkg::PS_DIV8: ps_last = cta_pkg::PS_LAST_8;
      cta_pkg::PS_DIV64: ps_last = cta_pkg::PS_LAST_64;
      cta_pkg::PS_DIV256: ps_last = cta_pkg::PS_LAST_256;
      default: ps_last = cta_pkg::PS_LAST_1;
    endcase
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ***************************************************
  // Avalon-MM slave: one wait cycle per access
  // ***************************************************
  wire req = read_in | write_in;
  wire acc_wr = write_in & ~waitrequest_out;
  wire word_rd = byteenable_in[1:0] == 2'b11;
  wire [3:0] idx = address_in;
  wire wide = timer_control_register[1][cta_pkg::WIDE_MODE_BIT];
  wire lp_en = oscillator_control_register[cta_pkg::LP_CRYSTAL_EN_BIT];
  wire [31:0] wide_count = {count_register[2], count_register[1]};
  wire [31:0] wide_period = {period_register[2], period_register[1]};
  wire wide_match = wide_count == wide_period;
  logic [15:0] rd_val;

  always_comb
  begin
    case (idx)
      cta_pkg::IDX_COUNT_A: rd_val = count_register[0];
      cta_pkg::IDX_PERIOD_A: rd_val = period_register[0];
      cta_pkg::IDX_CTRL_A: rd_val = timer_control_register[0];
      cta_pkg::IDX_LOWER_COUNT: rd_val = count_register[1];
      cta_pkg::IDX_LOWER_PERIOD: rd_val = period_register[1];
      cta_pkg::IDX_LOWER_CTRL: rd_val = timer_control_register[1];
      cta_pkg::IDX_UPPER_COUNT: rd_val = count_register[2];
      cta_pkg::IDX_UPPER_PERIOD: rd_val = period_register[2];
      cta_pkg::IDX_UPPER_CTRL: rd_val = timer_control_register[2];
      cta_pkg::IDX_IRQ_ENABLE: rd_val = irq_enable_reg_zero;
      cta_pkg::IDX_IRQ_FLAG: rd_val = irq_flag_reg_zero;
      cta_pkg::IDX_IRQ_PRIORITY: rd_val = irq_priority_reg_one;
      cta_pkg::IDX_OSC_CTRL: rd_val = oscillator_control_register;
      default: rd_val = cta_pkg::RST_WORD;
    endcase
  end

  // ***************************************************
  // Count clock, prescaler and increment per timer
  // ***************************************************
  // Pins are synchronous, so a plain one-flop edge detect suffices
  always_comb
  begin
    src_lvl[0] = lp_en ? lowpower_osc_in : external_count_pin_a_in;
    src_lvl[1] = external_count_pin_lower_in;
    src_lvl[2] = external_count_pin_upper_in;
  end

  always_comb
  begin
    logic tick;
    logic done;
    logic run;
    logic [15:0] ctl;
    tick = 1'b0;
    done = 1'b0;
    run = 1'b0;
    ctl = cta_pkg::RST_WORD;
    for (int i = 0; i < 3; i++)
    begin
      ctl = timer_control_register[i];
      wr_cnt[i] = acc_wr && idx == 4'(3 * i);
      run = ctl[cta_pkg::RUN_BIT];
      // Upper control is don't-care while paired
      if (i == 2 && wide)
      begin
        run = 1'b0;
      end
      tick = ctl[cta_pkg::CLOCK_SOURCE_BIT] ? (src_lvl[i] & ~src_prev[i]) : 1'b1;
      done = tick && presc[i] == ps_last(ctl[cta_pkg::PRESCALE_LSB +: 2]);
      if (!run || wr_cnt[i])
      begin
        next_presc[i] = 8'h00;
      end
      else if (done)
      begin
        next_presc[i] = 8'h00;
      end
      else if (tick)
      begin
        next_presc[i] = presc[i] + 8'h01;
      end
      else
      begin
        next_presc[i] = presc[i];
      end
      // Reads play no part here, so counting never stalls on them
      inc[i] = run && done && !wr_cnt[i];
    end
  end

  // ***************************************************
  // Next count and period-match flag events
  // ***************************************************
  always_comb
  begin
    logic [15:0] base;
    base = cta_pkg::RST_WORD;
    set_flag = 3'b000;
    for (int i = 0; i < 3; i++)
    begin
      // Byte merge keeps the untouched byte as it stood
      base = wr_cnt[i] ? merge(count_register[i], writedata_in, byteenable_in)
                       : count_register[i];
      next_count[i] = base;
      if (inc[i] && !(i == 1 && wide))
      begin
        if (count_register[i] == period_register[i])
        begin
          next_count[i] = cta_pkg::RST_WORD;
          set_flag[i] = period_register[i] != cta_pkg::RST_WORD;
        end
        else
        begin
          next_count[i] = count_register[i] + 16'h0001;
        end
      end
    end
    // Wide pair: lower tick drives both words
    if (wide && inc[1])
    begin
      if (wide_match)
      begin
        next_count[1] = cta_pkg::RST_WORD;
        if (!wr_cnt[2])
        begin
          next_count[2] = cta_pkg::RST_WORD;
        end
        set_flag[2] = wide_period != 32'h0000_0000;
      end
      else
      begin
        next_count[1] = count_register[1] + 16'h0001;
        // A pending write to the upper word takes precedence over the carry
        if (count_register[1] == cta_pkg::COUNT_ALL_ONES && !wr_cnt[2])
        begin
          next_count[2] = count_register[2] + 16'h0001;
        end
      end
    end
  end

  // ***************************************************
  // Flag events map to their interrupt bits
  // ***************************************************
  wire [15:0] flag_set_bits = (16'(set_flag[0]) << cta_pkg::IRQ_BIT_A)
    | (16'(set_flag[1]) << cta_pkg::IRQ_BIT_LOWER)
    | (16'(set_flag[2]) << cta_pkg::IRQ_BIT_UPPER);
  wire [15:0] flag_wr = (acc_wr && idx == cta_pkg::IDX_IRQ_FLAG)
    ? merge(irq_flag_reg_zero, writedata_in, byteenable_in) : irq_flag_reg_zero;
  // Set wins over a same-cycle software clear; hardware never clears
  wire [15:0] next_flag = flag_wr | flag_set_bits;
  wire [15:0] fe = next_flag & irq_enable_reg_zero;
  wire next_irq_a = fe[cta_pkg::IRQ_BIT_A]
    && irq_priority_reg_one[cta_pkg::PRIO_LSB_A +: 3] != 3'b000;
  wire next_irq_lower = fe[cta_pkg::IRQ_BIT_LOWER]
    && irq_priority_reg_one[cta_pkg::PRIO_LSB_LOWER +: 3] != 3'b000;
  wire next_wide_irq = fe[cta_pkg::IRQ_BIT_UPPER]
    && irq_priority_reg_one[cta_pkg::PRIO_LSB_UPPER +: 3] != 3'b000;

  // ***************************************************
  // Registers
  // ***************************************************
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      waitrequest_out <= 1'b1;
      readdata_out <= 32'h0000_0000;
      irq_a_out <= 1'b0;
      irq_lower_out <= 1'b0;
      wide_irq_out <= 1'b0;
      src_prev <= 3'b000;
      irq_enable_reg_zero <= cta_pkg::RST_WORD;
      irq_flag_reg_zero <= cta_pkg::RST_WORD;
      irq_priority_reg_one <= cta_pkg::RST_WORD;
      oscillator_control_register <= cta_pkg::RST_WORD;
      for (int i = 0; i < 3; i++)
      begin
        count_register[i] <= cta_pkg::RST_WORD;
        period_register[i] <= cta_pkg::RST_PERIOD;
        timer_control_register[i] <= cta_pkg::RST_WORD;
        presc[i] <= 8'h00;
      end
    end
    else
    begin
      waitrequest_out <= ~(req & waitrequest_out);
      if (req && waitrequest_out)
      begin
        readdata_out <= (read_in && word_rd) ? {16'h0000, rd_val} : 32'h0000_0000;
      end
      src_prev <= src_lvl;
      irq_flag_reg_zero <= next_flag;
      irq_a_out <= next_irq_a;
      irq_lower_out <= next_irq_lower;
      wide_irq_out <= next_wide_irq;
      for (int i = 0; i < 3; i++)
      begin
        count_register[i] <= next_count[i];
        presc[i] <= next_presc[i];
        if (acc_wr && idx == 4'(3 * i + 1))
        begin
          period_register[i] <= merge(period_register[i], writedata_in, byteenable_in);
        end
        if (acc_wr && idx == 4'(3 * i + 2))
        begin
          timer_control_register[i] <= merge(timer_control_register[i], writedata_in,
                                             byteenable_in);
        end
      end
      if (acc_wr && idx == cta_pkg::IDX_IRQ_ENABLE)
      begin
        irq_enable_reg_zero <= merge(irq_enable_reg_zero, writedata_in, byteenable_in);
      end
      if (acc_wr && idx == cta_pkg::IDX_IRQ_PRIORITY)
      begin
        irq_priority_reg_one <= merge(irq_priority_reg_one, writedata_in, byteenable_in);
      end
      if (acc_wr && idx == cta_pkg::IDX_OSC_CTRL)
      begin
        oscillator_control_register <= merge(oscillator_control_register, writedata_in,
                                             byteenable_in);
      end
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  wire lower_run = timer_control_register[1][cta_pkg::RUN_BIT];

  chk_word_write_masks: assert property (
    acc_wr && idx == cta_pkg::IDX_LOWER_COUNT && byteenable_in[1:0] == 2'b11
    |=> count_register[1] == $past(writedata_in[15:0]))
    else $error("count write did not mask increment");

  chk_low_byte_keep: assert property (
    acc_wr && idx == cta_pkg::IDX_COUNT_A && byteenable_in[1:0] == 2'b01
    |=> count_register[0] == {$past(count_register[0][15:8]), $past(writedata_in[7:0])})
    else $error("low byte write disturbed high byte");

  chk_high_byte_keep: assert property (
    acc_wr && idx == cta_pkg::IDX_COUNT_A && byteenable_in[1:0] == 2'b10
    |=> count_register[0][7:0] == $past(count_register[0][7:0]))
    else $error("high byte write disturbed low byte");

  chk_byte_read_zero: assert property (
    read_in && waitrequest_out && !word_rd |=> !waitrequest_out && readdata_out == 32'h0)
    else $error("byte read returned data");

  chk_stopped_holds: assert property (
    !lower_run && !wr_cnt[1] |=> count_register[1] == $past(count_register[1]))
    else $error("stopped lower timer changed");

  chk_upper_carry: assert property (
    wide && $past(wide) && !$past(wr_cnt[2]) && !$past(reset_in)
    && count_register[2] != $past(count_register[2])
    |-> $past(inc[1])
        && ($past(count_register[1]) == cta_pkg::COUNT_ALL_ONES || $past(wide_match)))
    else $error("upper word moved without carry");

  chk_upper_ignored: assert property (
    wide |-> !inc[2])
    else $error("upper timer counted on its own in wide mode");

  chk_wide_rollover: assert property (
    wide && inc[1] && wide_match && !wr_cnt[2] && wide_period != 32'h0000_0000
    |=> wide_count == 32'h0000_0000 && irq_flag_reg_zero[cta_pkg::IRQ_BIT_UPPER]
        && wide_irq_out == ($past(irq_enable_reg_zero[cta_pkg::IRQ_BIT_UPPER])
        && $past(irq_priority_reg_one[cta_pkg::PRIO_LSB_UPPER +: 3]) != 3'b000))
    else $error("wide match did not roll over and flag");

  chk_zero_period_quiet: assert property (
    period_register[0] == 16'h0000 |-> !set_flag[0])
    else $error("zero period raised a flag");

  chk_presc_cleared: assert property (
    !lower_run |=> presc[1] == 8'h00)
    else $error("prescaler not cleared while stopped");

  chk_lower_match_quiet: assert property (
    wide |-> !set_flag[1])
    else $error("lower match flagged in wide mode");

  chk_flag_sticky: assert property (
    irq_flag_reg_zero[cta_pkg::IRQ_BIT_UPPER] && !(acc_wr && idx == cta_pkg::IDX_IRQ_FLAG)
    |=> irq_flag_reg_zero[cta_pkg::IRQ_BIT_UPPER])
    else $error("flag cleared by hardware");

  cov_wide_match: cover property (wide && inc[1] && wide_match);
  cov_upper_carry: cover property (wide && inc[1] && count_register[1] == 16'hFFFF);
  cov_lp_tick: cover property (lp_en && inc[0]);
  cov_byte_write: cover property (wr_cnt[0] && byteenable_in[1:0] == 2'b01);
  cov_lower_alone: cover property (wide && inc[1] && !wide_match
    && count_register[1] == period_register[1]);
endmodule // cta_timer

// File: tb/cta_timer_tb_top.sv
module cta_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in;
  logic reset_in;
  logic [3:0] address_in;
  logic read_in;
  logic write_in;
  logic [31:0] writedata_in;
  logic [3:0] byteenable_in;
  logic pin_a;
  logic pin_lower;
  logic osc;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq_a;
  logic irq_lower;
  logic wide_irq;
  logic [31:0] rd;
  int miscompares;
  int n_checks;

  cta_timer i_cta_timer
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .address_in(address_in),
    .read_in(read_in),
    .write_in(write_in),
    .writedata_in(writedata_in),
    .byteenable_in(byteenable_in),
    .external_count_pin_a_in(pin_a),
    .external_count_pin_lower_in(pin_lower),
    .external_count_pin_upper_in(1'b0),
    .lowpower_osc_in(osc),
    .readdata_out(readdata),
    .waitrequest_out(waitrequest),
    .irq_a_out(irq_a),
    .irq_lower_out(irq_lower),
    .wide_irq_out(wide_irq)
  );

  // ***************************************************
  // Clock, reset and watchdog
  // ***************************************************
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    results();
  end

  task automatic results();
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ***************************************************
  // Bus, pin and compare helpers
  // ***************************************************
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  // Held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [3:0] be,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_in);
    read_in <= !wr;
    write_in <= wr;
    address_in <= addr;
    byteenable_in <= be;
    writedata_in <= wd;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100)
      miscompares++;
    rd = readdata;
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] addr, input logic [31:0] wd);
    bus(1'b1, addr, 4'h3, wd);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 4'h3, 32'h0000_0000);
    chk_word(what, exp, rd);
  endtask

  task automatic pulse(input int sel, input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      if (sel == 0) pin_a <= 1'b1;
      else if (sel == 1) pin_lower <= 1'b1;
      else osc <= 1'b1;
      repeat (2) @(posedge clk_in);
      pin_a <= 1'b0;
      pin_lower <= 1'b0;
      osc <= 1'b0;
      @(posedge clk_in);
    end
    repeat (3) @(posedge clk_in);
  endtask

  // ***************************************************
  // Scenarios
  // ***************************************************
  task automatic t_reset_and_reads();
    rd_chk("period a reset", cta_pkg::IDX_PERIOD_A, 32'h0000_FFFF);
    rd_chk("count a reset", cta_pkg::IDX_COUNT_A, 32'h0000_0000);
    rd_chk("unmapped read", 4'hD, 32'h0000_0000);
    bus(1'b0, cta_pkg::IDX_PERIOD_A, 4'h1, 32'h0000_0000);
    chk_word("byte read", 32'h0000_0000, rd);
  endtask

  task automatic t_byte_writes();
    wr(cta_pkg::IDX_CTRL_A, 32'h0000_8002);
    wr(cta_pkg::IDX_COUNT_A, 32'h0000_1234);
    bus(1'b1, cta_pkg::IDX_COUNT_A, 4'h1, 32'h0000_00FF);
    rd_chk("low byte write", cta_pkg::IDX_COUNT_A, 32'h0000_12FF);
    pulse(0, 1);
    rd_chk("low byte carry", cta_pkg::IDX_COUNT_A, 32'h0000_1300);
    bus(1'b1, cta_pkg::IDX_COUNT_A, 4'h1, 32'h0000_00FF);
    bus(1'b1, cta_pkg::IDX_COUNT_A, 4'h2, 32'h0000_5600);
    rd_chk("high byte write", cta_pkg::IDX_COUNT_A, 32'h0000_56FF);
    pulse(0, 1);
    rd_chk("high byte carry", cta_pkg::IDX_COUNT_A, 32'h0000_5700);
  endtask

  // Counts every clock: write edge holds, reads keep the pace
  task automatic t_write_mask();
    logic [31:0] v1;
    wr(cta_pkg::IDX_CTRL_A, 32'h0000_8000);
    wr(cta_pkg::IDX_COUNT_A, 32'h0000_0100);
    bus(1'b0, cta_pkg::IDX_COUNT_A, 4'h3, 32'h0000_0000);
    v1 = rd;
    chk_word("masked increment", 32'h0000_0101, v1);
    bus(1'b0, cta_pkg::IDX_COUNT_A, 4'h3, 32'h0000_0000);
    chk_word("read no stall", v1 + 32'h0000_0003, rd);
    bus(1'b0, cta_pkg::IDX_COUNT_A, 4'h1, 32'h0000_0000);
    chk_word("byte read count", 32'h0000_0000, rd);
  endtask

  task automatic t_lowpower_osc();
    wr(cta_pkg::IDX_CTRL_A, 32'h0000_8002);
    wr(cta_pkg::IDX_OSC_CTRL, 32'h0000_0002);
    wr(cta_pkg::IDX_COUNT_A, 32'h0000_0000);
    pulse(2, 2); // No count writes while the crystal keeps time
    pulse(0, 2);
    rd_chk("osc clocks timer a", cta_pkg::IDX_COUNT_A, 32'h0000_0002);
    wr(cta_pkg::IDX_OSC_CTRL, 32'h0000_0000);
  endtask

  task automatic t_zero_period();
    wr(cta_pkg::IDX_PERIOD_A, 32'h0000_0000);
    wr(cta_pkg::IDX_IRQ_PRIORITY, 32'h0000_0001);
    wr(cta_pkg::IDX_IRQ_ENABLE, 32'h0000_0008);
    wr(cta_pkg::IDX_IRQ_FLAG, 32'h0000_0000);
    // Count equals zero period at once, so a broken guard would flag
    wr(cta_pkg::IDX_COUNT_A, 32'h0000_0000);
    wr(cta_pkg::IDX_CTRL_A, 32'h0000_8000);
    repeat (20) @(posedge clk_in);
    rd_chk("zero period flag", cta_pkg::IDX_IRQ_FLAG, 32'h0000_0000);
    chk_bit("zero period irq", 1'b0, irq_a);
    wr(cta_pkg::IDX_PERIOD_A, 32'h0000_0003);
    repeat (10) @(posedge clk_in);
    rd_chk("period flag a", cta_pkg::IDX_IRQ_FLAG, 32'h0000_0008);
    chk_bit("irq a", 1'b1, irq_a);
    wr(cta_pkg::IDX_CTRL_A, 32'h0000_0000);
    wr(cta_pkg::IDX_IRQ_FLAG, 32'h0000_0000);
  endtask

  task automatic t_prescale();
    int ratio [4] = '{1, 8, 64, 256};
    for (int i = 0; i < 4; i++)
    begin
      wr(cta_pkg::IDX_LOWER_CTRL, 32'h0000_8002 | (32'(i) << cta_pkg::PRESCALE_LSB));
      wr(cta_pkg::IDX_LOWER_COUNT, 32'h0000_0000);
      pulse(1, ratio[i] - 1);
      rd_chk("prescale short", cta_pkg::IDX_LOWER_COUNT, 32'h0000_0000);
      pulse(1, 1);
      rd_chk("prescale tick", cta_pkg::IDX_LOWER_COUNT, 32'h0000_0001);
    end
  endtask

  // Upper control set running on purpose: it must not count in wide mode
  task automatic t_wide();
    wr(cta_pkg::IDX_LOWER_PERIOD, 32'h0000_0001);
    wr(cta_pkg::IDX_UPPER_PERIOD, 32'h0000_0001);
    wr(cta_pkg::IDX_IRQ_PRIORITY, 32'h0000_1100);
    wr(cta_pkg::IDX_IRQ_ENABLE, 32'h0000_00C0);
    wr(cta_pkg::IDX_LOWER_CTRL, 32'h0000_800A);
    wr(cta_pkg::IDX_UPPER_CTRL, 32'h0000_8000);
    wr(cta_pkg::IDX_LOWER_COUNT, 32'h0000_0000);
    wr(cta_pkg::IDX_UPPER_COUNT, 32'h0000_0000);
    // Second tick meets the lower period alone
    pulse(1, 2);
    rd_chk("lower match alone", cta_pkg::IDX_LOWER_COUNT, 32'h0000_0002);
    rd_chk("upper ctrl ignored", cta_pkg::IDX_UPPER_COUNT, 32'h0000_0000);
    rd_chk("no lower irq flag", cta_pkg::IDX_IRQ_FLAG, 32'h0000_0000);
    wr(cta_pkg::IDX_LOWER_COUNT, 32'h0000_FFFF);
    pulse(1, 1);
    rd_chk("lower wraps", cta_pkg::IDX_LOWER_COUNT, 32'h0000_0000);
    rd_chk("upper on carry", cta_pkg::IDX_UPPER_COUNT, 32'h0000_0001);
    pulse(1, 2);
    rd_chk("match lower clear", cta_pkg::IDX_LOWER_COUNT, 32'h0000_0000);
    rd_chk("match upper clear", cta_pkg::IDX_UPPER_COUNT, 32'h0000_0000);
    rd_chk("wide flag", cta_pkg::IDX_IRQ_FLAG, 32'h0000_0080);
    chk_bit("wide irq", 1'b1, wide_irq);
    chk_bit("lower irq unused", 1'b0, irq_lower);
    pulse(1, 1);
    rd_chk("keeps counting", cta_pkg::IDX_LOWER_COUNT, 32'h0000_0001);
    rd_chk("flag sticks", cta_pkg::IDX_IRQ_FLAG, 32'h0000_0080);
    wr(cta_pkg::IDX_IRQ_FLAG, 32'h0000_0000);
    @(posedge clk_in);
    chk_bit("wide irq cleared", 1'b0, wide_irq);
    wr(cta_pkg::IDX_LOWER_CTRL, 32'h0000_000A);
    pulse(1, 2);
    rd_chk("stopped without run", cta_pkg::IDX_LOWER_COUNT, 32'h0000_0001);
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial
  begin
    reset_in = 1'b1;
    address_in = 4'h0;
    read_in = 1'b0;
    write_in = 1'b0;
    writedata_in = 32'h0000_0000;
    byteenable_in = 4'h0;
    pin_a = 1'b0;
    pin_lower = 1'b0;
    osc = 1'b0;
    miscompares = 0;
    n_checks = 0;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk_bit("waitrequest idle", 1'b1, waitrequest);
    t_reset_and_reads();
    t_byte_writes();
    t_write_mask();
    t_lowpower_osc();
    t_zero_period();
    t_prescale();
    t_wide();
    results();
  end
endmodule // cta_timer_tb_top
